// ==== hdl/aic_cfg.svh ====
// Constants of the auxiliary interrupt controller.
// Assumes the including file is compiled after aic_pkg.
`ifndef AIC_CFG_SVH
`define AIC_CFG_SVH

// ----------------------------------------
// Register offsets on the SFR port
// ----------------------------------------
`define AIC_OFS_POLL      8'ha4
`define AIC_OFS_PAI       8'ha5
`define AIC_OFS_MASK      8'ha6
`define AIC_OFS_IE        8'ha8
`define AIC_OFS_EXTENDED_INT_CONTROL     8'hd8
`define AIC_OFS_SECOND_TIMER_INT_REG    8'hf9
`define AIC_OFS_SUMLOW    8'he2
`define AIC_OFS_CONVLOW   8'hd9
`define AIC_OFS_MS_TIMER_INT_REG     8'hfa
`define AIC_OFS_SERDATA   8'h9b

// ----------------------------------------
// Field positions, write masks, resets
// ----------------------------------------
`define AIC_EXTENDED_INT_CONTROL_AUXEN   4
`define AIC_IE_GLOBAL     7
`define AIC_MASK_WMASK    8'hfe
`define AIC_IE_WMASK      8'h9f
`define AIC_RST_BYTE      8'h00
`define AIC_AUX_VECTOR    16'h0033

// ----------------------------------------
// Pending index codes
// ----------------------------------------
`define AIC_PAI_NONE      4'h0
`define AIC_PAI_RSVD      4'h1
`define AIC_PAI_ALV       4'h2
`define AIC_PAI_TWI       4'h3
`define AIC_PAI_CNT       4'h4
`define AIC_PAI_MS_TIMER_FLAG      4'h5
`define AIC_PAI_ADC       4'h6
`define AIC_PAI_SUM       4'h7
`define AIC_PAI_SEC       4'h8

`endif

// ==== hdl/aic_ext_req.sv ====
// Request detector for one active-low external interrupt pin.
// Assumes the pin is synchronous to mclk_i.
`timescale 1ns/1ps

module aic_ext_req (
    input  wire logic mclk_i,
    input  wire logic resetn_i,
    input  wire logic pin_n_i,
    input  wire logic edge_mode_i,
    input  wire logic ack_i,
    output logic      req_o
);

    aic_pkg::aic_ext_state_t st;
    aic_pkg::aic_ext_state_t next_st;

    // Edge mode latches a fall until acknowledged; level mode follows a low pin.
    always_comb begin
        next_st      = st;
        next_st.prev = pin_n_i;
        if (st.prev && !pin_n_i) begin
            next_st.flag = 1'b1;
        end else if (ack_i) begin
            next_st.flag = 1'b0;
        end
        next_st.req  = edge_mode_i ? next_st.flag : !pin_n_i;
    end

    // State register; the pin is taken as idle high at reset.
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            st <= '{prev: 1'b1, flag: 1'b0, req: 1'b0};
        end else begin
            st <= next_st;
        end
    end

    assign req_o = st.req;

endmodule // aic_ext_req

// ==== hdl/aic_pkg.sv ====
// Types shared by the auxiliary interrupt controller files.
// Assumes nothing of its surroundings.
package aic_pkg;

    // Auxiliary sources in the bit layout of the mask and status bytes.
    typedef struct packed {
        logic sec;
        logic sum;
        logic adc;
        logic ms_timer_flag;
        logic twi;
        logic cnt;
        logic alv;
        logic rsvd;
    } aic_aux_src_t;

    // One SFR access from the core.
    typedef struct packed {
        logic [7:0] addr;
        logic       wr;
        logic       rd;
        logic [7:0] wdata;
    } aic_sfr_req_t;

    // Standard request flags from serial port 0 and the timers.
    typedef struct packed {
        logic s0_rx;
        logic s0_tx;
        logic t1_ovf;
        logic t0_ovf;
    } aic_std_src_t;

    // Gated standard requests toward the core.
    typedef struct packed {
        logic s0;
        logic t1;
        logic x1;
        logic t0;
        logic x0;
    } aic_std_irq_t;

    // Whole state of the top module, apart from the state held in the two pin detectors.
    typedef struct packed {
        logic [7:0]   mask;
        aic_aux_src_t raw;
        logic         aux_en;
        logic [7:0]   ie;
        logic [3:0]   aux_pending_index;
        logic         aux_irq;
        aic_std_irq_t std;
        logic [7:0]   rdata;
        logic         hit;
    } aic_state_t;

    // State of one external pin detector.
    typedef struct packed {
        logic prev;
        logic flag;
        logic req;
    } aic_ext_state_t;

endpackage

// ==== hdl/aic_prio_enc.sv ====
// Priority encoder for the pending auxiliary index.
// Assumes enabled status bits in the mask byte layout.
`timescale 1ns/1ps
`include "aic_cfg.svh"

module aic_prio_enc (
    input  wire aic_pkg::aic_aux_src_t status_i,
    output logic [3:0]                 code_o
);

    // Lowest priority first, so a higher one overwrites it.
    always_comb begin
        code_o = `AIC_PAI_NONE;
        if (status_i.sec) begin
            code_o = `AIC_PAI_SEC;
        end
        if (status_i.sum) begin
            code_o = `AIC_PAI_SUM;
        end
        if (status_i.adc) begin
            code_o = `AIC_PAI_ADC;
        end
        if (status_i.ms_timer_flag) begin
            code_o = `AIC_PAI_MS_TIMER_FLAG;
        end
        if (status_i.cnt) begin
            code_o = `AIC_PAI_CNT;
        end
        if (status_i.twi) begin
            code_o = `AIC_PAI_TWI;
        end
        if (status_i.alv) begin
            code_o = `AIC_PAI_ALV;
        end
    end

endmodule // aic_prio_enc

// ==== hdl/aic_top.sv ====
// Auxiliary and standard interrupt aggregation behind the SFR port.
// Assumes the core issues one-cycle SFR read and write strobes and
// that source event inputs other than the alv level are one-cycle pulses on mclk_i.
`timescale 1ns/1ps
`include "aic_cfg.svh"

module aic_top (
    input  wire logic                  mclk_i,
    input  wire logic                  resetn_i,
    input  wire aic_pkg::aic_sfr_req_t sfr_i,
    input  wire aic_pkg::aic_aux_src_t aux_evt_i,
    input  wire aic_pkg::aic_std_src_t std_src_i,
    input  wire logic                  ext_irq0_pin_n_i,
    input  wire logic                  ext_irq1_pin_n_i,
    input  wire logic [1:0]            ext_edge_mode_i,
    input  wire logic [1:0]            ext_ack_i,
    output logic [7:0]                 sfr_rdata_o,
    output logic                       sfr_hit_o,
    output logic                       aux_irq_o,
    output logic [15:0]                aux_vector_o,
    output aic_pkg::aic_std_irq_t      std_irq_o,
    output logic [7:0]                 aux_mask_o,
    output logic                       conv_result_hold_o
);

    // ----------------------------------------
    // State and decode
    // ----------------------------------------
    aic_pkg::aic_state_t   st;
    aic_pkg::aic_state_t   next_st;
    aic_pkg::aic_aux_src_t status;
    logic [3:0]            pai_code;
    logic [1:0]            ext_req;
    logic                  rd_sec;
    logic                  rd_sum;
    logic                  rd_conv;
    logic                  rd_ms;
    logic                  wr_ser;
    logic                  rd_ser;

    // Clearing accesses seen on the SFR port.
    assign rd_sec  = sfr_i.rd && (sfr_i.addr == `AIC_OFS_SECOND_TIMER_INT_REG);
    assign rd_sum  = sfr_i.rd && (sfr_i.addr == `AIC_OFS_SUMLOW);
    assign rd_conv = sfr_i.rd && (sfr_i.addr == `AIC_OFS_CONVLOW);
    assign rd_ms   = sfr_i.rd && (sfr_i.addr == `AIC_OFS_MS_TIMER_INT_REG);
    assign wr_ser  = sfr_i.wr && (sfr_i.addr == `AIC_OFS_SERDATA);
    assign rd_ser  = sfr_i.rd && (sfr_i.addr == `AIC_OFS_SERDATA);

    // Status is the raw flag gated by its mask; bit 0 stays zero.
    assign status = st.raw & st.mask & `AIC_MASK_WMASK;

    // ----------------------------------------
    // Sub-blocks
    // ----------------------------------------

    // Highest-priority enabled source picks the index.
    aic_prio_enc i_aic_prio_enc (
        .status_i (status),
        .code_o   (pai_code)
    );

    // One detector per external pin.
    for (genvar g = 0; g < 2; g++) begin : g_ext
        aic_ext_req i_aic_ext_req (
            .mclk_i      (mclk_i),
            .resetn_i    (resetn_i),
            .pin_n_i     ((g == 0) ? ext_irq0_pin_n_i : ext_irq1_pin_n_i),
            .edge_mode_i (ext_edge_mode_i[g]),
            .ack_i       (ext_ack_i[g]),
            .req_o       (ext_req[g])
        );
    end

    // ----------------------------------------
    // Next state
    // ----------------------------------------

    // Flags set on their events, which win over a clear in the same cycle.
    always_comb begin
        next_st = st;

        // Software clears by access to the owning data registers.
        if (rd_sec) begin
            next_st.raw.sec = 1'b0;
        end
        if (rd_sum) begin
            next_st.raw.sum = 1'b0;
        end
        if (rd_conv) begin
            next_st.raw.adc = 1'b0;
        end
        if (rd_ms) begin
            next_st.raw.ms_timer_flag = 1'b0;
        end
        if (wr_ser) begin
            next_st.raw.twi = 1'b0;
        end
        if (wr_ser || rd_ser) begin
            next_st.raw.cnt = 1'b0;
        end

        // Event pulses set the raw flags.
        if (aux_evt_i.sec) begin
            next_st.raw.sec = 1'b1;
        end
        if (aux_evt_i.sum) begin
            next_st.raw.sum = 1'b1;
        end
        if (aux_evt_i.adc) begin
            next_st.raw.adc = 1'b1;
        end
        if (aux_evt_i.ms_timer_flag) begin
            next_st.raw.ms_timer_flag = 1'b1;
        end
        if (aux_evt_i.twi) begin
            next_st.raw.twi = 1'b1;
        end
        if (aux_evt_i.cnt) begin
            next_st.raw.cnt = 1'b1;
        end

        // Low-voltage flag follows the below-threshold level.
        next_st.raw.alv  = aux_evt_i.alv;
        next_st.raw.rsvd = 1'b0;

        // Register writes; unused bits are dropped.
        if (sfr_i.wr) begin
            unique case (sfr_i.addr)
                `AIC_OFS_MASK: begin
                    next_st.mask = sfr_i.wdata & `AIC_MASK_WMASK;
                end
                `AIC_OFS_IE: begin
                    next_st.ie = sfr_i.wdata & `AIC_IE_WMASK;
                end
                `AIC_OFS_EXTENDED_INT_CONTROL: begin
                    next_st.aux_en = sfr_i.wdata[`AIC_EXTENDED_INT_CONTROL_AUXEN];
                end
                default: begin
                end
            endcase
        end

        // Read data is captured on the strobe and stands until the next read.
        if (sfr_i.rd) begin
            next_st.hit   = 1'b1;
            next_st.rdata = `AIC_RST_BYTE;
            unique case (sfr_i.addr)
                `AIC_OFS_POLL: begin
                    next_st.rdata = st.raw & `AIC_MASK_WMASK;
                end
                `AIC_OFS_PAI: begin
                    next_st.rdata = {4'h0, st.aux_pending_index};
                end
                `AIC_OFS_MASK: begin
                    next_st.rdata = status;
                end
                `AIC_OFS_IE: begin
                    next_st.rdata = st.ie;
                end
                `AIC_OFS_EXTENDED_INT_CONTROL: begin
                    next_st.rdata[`AIC_EXTENDED_INT_CONTROL_AUXEN] = st.aux_en;
                end
                default: begin
                    next_st.hit = 1'b0;
                end
            endcase
        end

        // Index and auxiliary request, one cycle behind the flags.
        next_st.aux_pending_index     = pai_code;
        next_st.aux_irq = (pai_code != `AIC_PAI_NONE) && st.aux_en;

        // Standard requests under the global enable.
        next_st.std.s0 = st.ie[`AIC_IE_GLOBAL] && st.ie[4]
                         && (std_src_i.s0_rx || std_src_i.s0_tx);
        next_st.std.t1 = st.ie[`AIC_IE_GLOBAL] && st.ie[3]
                         && std_src_i.t1_ovf;
        next_st.std.t0 = st.ie[`AIC_IE_GLOBAL] && st.ie[1]
                         && std_src_i.t0_ovf;
        next_st.std.x1 = st.ie[`AIC_IE_GLOBAL] && st.ie[2] && ext_req[1];
        next_st.std.x0 = st.ie[`AIC_IE_GLOBAL] && st.ie[0] && ext_req[0];
    end

    // ----------------------------------------
    // State register
    // ----------------------------------------

    // All control state clears at reset.
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // Outputs come from the state register; the vector is fixed.
    assign sfr_rdata_o        = st.rdata;
    assign sfr_hit_o          = st.hit;
    assign aux_irq_o          = st.aux_irq;
    assign aux_vector_o       = `AIC_AUX_VECTOR;
    assign std_irq_o          = st.std;
    assign aux_mask_o         = st.mask;
    assign conv_result_hold_o = st.raw.adc;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!resetn_i);

    // Idle status yields a zero index next cycle.
    AST_PAI_IDLE_ZERO: assert property (
        (status == 8'h00) |=> (st.aux_pending_index == `AIC_PAI_NONE))
        else $error("index not zero while idle");

    // The reserved code never appears.
    AST_PAI_NO_RSVD: assert property (
        st.aux_pending_index != `AIC_PAI_RSVD)
        else $error("reserved index reported");

    // Low voltage wins over everything else.
    AST_PAI_ALV_TOP: assert property (
        status.alv |=> (st.aux_pending_index == `AIC_PAI_ALV))
        else $error("low voltage not top priority");

    // Two-wire outranks bit count.
    AST_PAI_TWI_OVER_CNT: assert property (
        (status == 8'h0c) |=> (st.aux_pending_index == `AIC_PAI_TWI))
        else $error("two-wire priority wrong");

    // Second timer alone gives the highest code.
    AST_PAI_SEC_ALONE: assert property (
        (status == 8'h80) |=> (st.aux_pending_index == `AIC_PAI_SEC))
        else $error("second timer code wrong");

    // A mask write is seen on the next cycle with bit 0 cleared.
    AST_MASK_WRITE: assert property (
        (sfr_i.wr && sfr_i.addr == `AIC_OFS_MASK)
        |=> (aux_mask_o == ($past(sfr_i.wdata) & 8'hfe)))
        else $error("mask write not applied");

    // Reading the second-timer register clears a flag with no new event.
    AST_SEC_CLEAR: assert property (
        (rd_sec && !aux_evt_i.sec) |=> !st.raw.sec)
        else $error("second timer flag not cleared");

    // An event in the clearing cycle is kept.
    AST_SEC_SET_WINS: assert property (
        (rd_sec && aux_evt_i.sec) |=> st.raw.sec)
        else $error("event lost on clear");

    // Summation clears on its low result read.
    AST_SUM_CLEAR: assert property (
        (rd_sum && !aux_evt_i.sum) |=> !st.raw.sum)
        else $error("summation flag not cleared");

    // Converter hold tracks its flag through the clear.
    AST_CONV_HOLD: assert property (
        (rd_conv && !aux_evt_i.adc) |=> !conv_result_hold_o)
        else $error("converter hold not released");

    // Bit-count clears on a serial data write.
    AST_CNT_CLEAR: assert property (
        (wr_ser && !aux_evt_i.cnt) |=> !st.raw.cnt)
        else $error("bit count flag not cleared");

    // Low-voltage flag drops once the level goes away.
    AST_ALV_FOLLOW: assert property (
        !aux_evt_i.alv |=> !st.raw.alv)
        else $error("low voltage flag stuck");

    // Auxiliary request matches index and enable.
    AST_AUX_IRQ: assert property (
        aux_irq_o == ((st.aux_pending_index != 4'h0) && $past(st.aux_en)))
        else $error("auxiliary request mismatch");

    // Global enable low silences standard requests.
    AST_EA_BLOCK: assert property (
        !st.ie[7] |=> (std_irq_o == 5'b0_0000))
        else $error("standard request while disabled");

    // Main scenarios.
    COV_SEC_PENDING: cover property (st.aux_pending_index == `AIC_PAI_SEC);
    COV_AUX_IRQ: cover property ($rose(aux_irq_o));
    COV_SERIAL_IRQ: cover property (std_irq_o.s0);
    COV_SET_WINS: cover property (rd_sec && aux_evt_i.sec);

endmodule // aic_top

// ==== test/aic_core_model.sv ====
// Model of the processor core that reaches the controller over the SFR port.
// Assumes a free-running mclk_i; the bench calls the two bus tasks.
`timescale 1ns/1ps

module aic_core_model (
    input  wire logic             mclk_i,
    input  wire logic [7:0]       rdata_i,
    input  wire logic             hit_i,
    output aic_pkg::aic_sfr_req_t sfr_o
);
    // ----------------------------------------
    // Bus cycles
    // ----------------------------------------
    // The port starts idle with no strobe.
    initial begin
        sfr_o = '0;
    end

    // One write strobe, held until the rising edge that takes it.
    task automatic sfr_write(input logic [7:0] addr, input logic [7:0] data);
        @(posedge mclk_i);
        #1;
        sfr_o = '{addr: addr, wr: 1'b1, rd: 1'b0, wdata: data};
        @(posedge mclk_i);
        #1;
        sfr_o = '{addr: ~addr, wr: 1'b0, rd: 1'b0, wdata: ~data}; // Stale lines do not linger.
    endtask

    // One read strobe; the registered answer is taken one cycle later.
    task automatic sfr_read(input logic [7:0] addr, output logic [7:0] data, output logic hit);
        @(posedge mclk_i);
        #1;
        sfr_o = '{addr: addr, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
        @(posedge mclk_i);
        #1;
        sfr_o = '{addr: ~addr, wr: 1'b0, rd: 1'b0, wdata: 8'hff};
        data = rdata_i;
        hit = hit_i;
    endtask
endmodule // aic_core_model

// ==== test/aic_top_tb_top.sv ====
// Self-checking bench of the auxiliary interrupt controller.
// Assumes the core model drives the SFR port and the bench drives the sources.
`timescale 1ns/1ps
`include "aic_cfg.svh"

module aic_top_tb_top;
    logic                  mclk;
    logic                  resetn;
    aic_pkg::aic_sfr_req_t sfr;
    aic_pkg::aic_aux_src_t aux_evt;
    aic_pkg::aic_std_src_t std_src;
    logic                  pin0_n;
    logic                  pin1_n;
    logic [1:0]            edge_mode;
    logic [1:0]            ack;
    logic [7:0]            rdata;
    logic                  hit;
    logic                  aux_irq;
    logic [15:0]           vector;
    aic_pkg::aic_std_irq_t std_irq;
    logic [7:0]            mask;
    logic                  hold;
    int                    n_fail;
    int                    check_count;

    // ----------------------------------------
    // Clock, instances and helpers
    // ----------------------------------------
    // The 100 MHz core clock.
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    aic_top i_aic_top (.mclk_i(mclk), .resetn_i(resetn), .sfr_i(sfr), .aux_evt_i(aux_evt),
        .std_src_i(std_src), .ext_irq0_pin_n_i(pin0_n), .ext_irq1_pin_n_i(pin1_n),
        .ext_edge_mode_i(edge_mode), .ext_ack_i(ack), .sfr_rdata_o(rdata), .sfr_hit_o(hit),
        .aux_irq_o(aux_irq), .aux_vector_o(vector), .std_irq_o(std_irq), .aux_mask_o(mask),
        .conv_result_hold_o(hold));

    aic_core_model i_aic_core_model (.mclk_i(mclk), .rdata_i(rdata), .hit_i(hit), .sfr_o(sfr));

    // Steps n edges and lands just after the last one.
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic rd_chk(input string name, input logic [7:0] addr, input logic [7:0] exp);
        logic [7:0] d;
        logic       h;
        i_aic_core_model.sfr_read(addr, d, h);
        chk(name, {8'h00, exp}, {8'h00, d});
    endtask

    // Reads the pending index and checks the request toward the core beside it.
    task automatic idx_chk(input logic [3:0] exp, input logic irq);
        rd_chk("index", `AIC_OFS_PAI, {4'h0, exp});
        chk("aux_irq", {15'h0000, irq}, {15'h0000, aux_irq});
    endtask

    // One-cycle event pulses on the software-cleared sources; alv is left alone.
    task automatic pulse(input logic [7:0] e);
        aux_evt[7:2] = e[7:2];
        tick(1);
        aux_evt[7:2] = 6'h00;
    endtask

    // A clearing access, then the index that should remain.
    task automatic rd_clr(input logic [7:0] addr, input logic [3:0] exp);
        logic [7:0] d;
        logic       h;
        i_aic_core_model.sfr_read(addr, d, h);
        tick(3);
        idx_chk(exp, exp != 4'h0);
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic test_reset();
        logic [7:0] d;
        logic       h;
        chk("vector", 16'h0033, vector);
        chk("mask_rst", 16'h0000, {8'h00, mask});
        i_aic_core_model.sfr_read(`AIC_OFS_PAI, d, h);
        chk("index_rst", 16'h0100, {7'h00, h, d});
        rd_chk("status_rst", `AIC_OFS_MASK, 8'h00);
        rd_chk("ie_rst", `AIC_OFS_IE, 8'h00);
    endtask

    task automatic test_regs();
        i_aic_core_model.sfr_write(`AIC_OFS_MASK, 8'hff);
        tick(1);
        chk("mask_bits", 16'h00fe, {8'h00, mask});
        i_aic_core_model.sfr_write(`AIC_OFS_MASK, 8'h54);
        tick(1);
        chk("mask_back", 16'h0054, {8'h00, mask});
        i_aic_core_model.sfr_write(`AIC_OFS_IE, 8'hff);
        rd_chk("ie_bits", `AIC_OFS_IE, 8'h9f);
        i_aic_core_model.sfr_write(`AIC_OFS_PAI, 8'hff);
        rd_chk("index_ro", `AIC_OFS_PAI, 8'h00);
        i_aic_core_model.sfr_write(`AIC_OFS_IE, 8'h00);
    endtask

    // All sources at once, then peeled off by dropping alv and by clearing accesses; one serial data write clears twi and cnt together.
    task automatic test_priority();
        i_aic_core_model.sfr_write(`AIC_OFS_EXTENDED_INT_CONTROL, 8'h10);
        i_aic_core_model.sfr_write(`AIC_OFS_MASK, 8'hfe);
        aux_evt.alv = 1'b1;
        pulse(8'hfc);
        tick(3);
        rd_chk("status_all", `AIC_OFS_MASK, 8'hfe);
        rd_chk("poll_all", `AIC_OFS_POLL, 8'hfe);
        idx_chk(4'h2, 1'b1);
        aux_evt.alv = 1'b0;
        tick(3);
        idx_chk(4'h3, 1'b1);
        i_aic_core_model.sfr_write(`AIC_OFS_SERDATA, 8'h00);
        tick(3);
        idx_chk(4'h5, 1'b1);
        chk("hold_on", 16'h0001, {15'h0000, hold});
        rd_clr(`AIC_OFS_MS_TIMER_INT_REG, 4'h6);
        rd_clr(`AIC_OFS_CONVLOW, 4'h7);
        chk("hold_off", 16'h0000, {15'h0000, hold});
        rd_clr(`AIC_OFS_SUMLOW, 4'h8);
        rd_clr(`AIC_OFS_SECOND_TIMER_INT_REG, 4'h0);
        pulse(8'h04);
        tick(3);
        idx_chk(4'h4, 1'b1);
        rd_clr(`AIC_OFS_SERDATA, 4'h0);
    endtask

    // A masked source shows only in the poll view; the auxiliary enable gates delivery.
    task automatic test_masked();
        i_aic_core_model.sfr_write(`AIC_OFS_MASK, 8'h00);
        pulse(8'h80);
        tick(3);
        rd_chk("status_msk", `AIC_OFS_MASK, 8'h00);
        rd_chk("poll_msk", `AIC_OFS_POLL, 8'h80);
        idx_chk(4'h0, 1'b0);
        i_aic_core_model.sfr_write(`AIC_OFS_MASK, 8'h80);
        i_aic_core_model.sfr_write(`AIC_OFS_EXTENDED_INT_CONTROL, 8'h00);
        i_aic_core_model.sfr_write(`AIC_OFS_IE, 8'h80);
        tick(3);
        idx_chk(4'h8, 1'b0);
        i_aic_core_model.sfr_write(`AIC_OFS_EXTENDED_INT_CONTROL, 8'h10);
        tick(3);
        idx_chk(4'h8, 1'b1);
        rd_clr(`AIC_OFS_SECOND_TIMER_INT_REG, 4'h0);
    endtask

    // Each standard enable alone under the global enable, then all five without it.
    task automatic test_std();
        std_src = 4'hf;
        pin0_n = 1'b0;
        pin1_n = 1'b0;
        for (int i = 0; i < 5; i++) begin
            i_aic_core_model.sfr_write(`AIC_OFS_IE, 8'h80 | (8'h01 << i));
            tick(3);
            chk("std_on", 16'h0001 << i, {11'h000, std_irq});
            i_aic_core_model.sfr_write(`AIC_OFS_IE, 8'h1f);
            tick(3);
            chk("std_off", 16'h0000, {11'h000, std_irq});
        end
        i_aic_core_model.sfr_write(`AIC_OFS_IE, 8'h90);
        std_src = 4'h4;
        tick(2);
        chk("s0_tx", 16'h0010, {11'h000, std_irq});
        std_src = 4'h8;
        tick(2);
        chk("s0_rx", 16'h0010, {11'h000, std_irq});
        std_src = 4'h0;
        pin0_n = 1'b1;
        pin1_n = 1'b1;
        edge_mode = 2'b01;
        // The level phase latched a fall on both pins; drop it before the edge test.
        ack = 2'b11;
        tick(1);
        ack = 2'b00;
        i_aic_core_model.sfr_write(`AIC_OFS_IE, 8'h81);
        tick(3);
        chk("x0_idle", 16'h0000, {11'h000, std_irq});
        pin0_n = 1'b0;
        tick(1);
        pin0_n = 1'b1;
        tick(3);
        chk("x0_edge", 16'h0001, {11'h000, std_irq});
        ack = 2'b01;
        tick(1);
        ack = 2'b00;
        tick(3);
        chk("x0_ack", 16'h0000, {11'h000, std_irq});
    endtask

    // ----------------------------------------
    // Run control
    // ----------------------------------------
    task automatic summarize();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // Main sequence after a 16-cycle reset.
    initial begin
        n_fail = 0;
        check_count = 0;
        resetn = 1'b0;
        aux_evt = '0;
        std_src = '0;
        pin0_n = 1'b1;
        pin1_n = 1'b1;
        edge_mode = 2'b00;
        ack = 2'b00;
        tick(16);
        resetn = 1'b1;
        tick(1);
        test_reset();
        test_regs();
        test_priority();
        test_masked();
        test_std();
        summarize();
    end

    // Cuts a hang short and counts it as a mismatch.
    initial begin
        repeat (20000) @(posedge mclk);
        n_fail++;
        summarize();
    end
endmodule // aic_top_tb_top
